// ===== aqs_pkg.sv
// Package for the queued converter scan control block.
// Assumes a single 250 MHz clock domain and a simple strobe register port.
package aqs_pkg;
	// Register word offsets
	localparam logic [7:0] ADDR_MODULE_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_INTERRUPT      = 8'h01;
	localparam logic [7:0] ADDR_FACTORY_TEST   = 8'h02;
	localparam logic [7:0] ADDR_HW_CONFIG      = 8'h03;
	localparam logic [7:0] ADDR_Q1_CONTROL     = 8'h04;
	localparam logic [7:0] ADDR_Q2_CONTROL     = 8'h05;
	localparam logic [7:0] ADDR_STATUS_LOW     = 8'h06;
	localparam logic [7:0] ADDR_STATUS_HIGH    = 8'h07;
	localparam logic [7:0] ADDR_CMD_BASE       = 8'h40; // 64 command words
	localparam logic [7:0] ADDR_RES_BASE0      = 8'h80; // Result window 0
	localparam logic [7:0] ADDR_RES_BASE1      = 8'hC0; // Result window 1
	localparam logic [7:0] ADDR_RES_BASE2      = 8'h00; // Window 2 on page bit
	// Queue control fields
	localparam int          CTL_SSE_BIT        = 0;
	localparam int          CTL_MODE_LSB       = 1;
	localparam int          CTL_EDGE_BIT       = 3;
	// Command word fields
	localparam int          CMD_PAUSE_BIT      = 9;
	localparam int          CMD_EOQ_BIT        = 8;
	localparam logic [9:0]  CMD_RESET          = 10'h100;
	localparam logic [15:0] REG_RESET          = 16'h0000;
	localparam logic [5:0]  CONV_CYCLES        = 6'h04;
	typedef enum logic [1:0] {
		AQS_MODE_OFF  = 2'b00,
		AQS_MODE_SOFT = 2'b01,
		AQS_MODE_EDGE = 2'b10,
		AQS_MODE_GATE = 2'b11
	} aqs_mode_t;
	typedef enum logic [1:0] {
		AQS_IDLE  = 2'b00,
		AQS_RUN   = 2'b01,
		AQS_PAUSE = 2'b10
	} aqs_state_t;
endpackage

// ===== aqs_scan_ctrl.sv
// Queue scan sequencer with command table, result table and control registers.
// Assumes register port on ref_clk; trigger pins are asynchronous.
module aqs_scan_ctrl
	import aqs_pkg::*;
#(
	parameter int CMD_DEPTH = 64
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [8:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_supervisor,
	output logic      [15:0] reg_rdata,
	input  wire logic        trig_q1_pin,
	input  wire logic        trig_q2_pin,
	input  wire logic [9:0]  conv_data,
	output logic             conv_start,
	output logic      [5:0]  conv_channel
);
	// Depth is tied to the six-bit pointer, so any other depth is refused
	if (CMD_DEPTH != 64) begin : g_depth_chk
		$error("CMD_DEPTH must be 64");
	end

	// Tables: command table and one shared result table
	logic [9:0]  cmd_mem [CMD_DEPTH];
	logic [9:0]  res_mem [CMD_DEPTH];
	logic [15:0] mcfg_q, intr_q, test_q, hwcfg_q, q1ctl_q, q2ctl_q;
	logic [15:0] q1ctl_d, q2ctl_d;
	logic        cf1_q, pf1_q, cf2_q, pf2_q, tor_q;
	logic        cf1_d, pf1_d, cf2_d, pf2_d, tor_d;
	logic [2:0]  s1_q, s2_q;
	logic        e1_q, e2_q;
	aqs_state_t  st_q, st_d;
	logic        qsel_q, qsel_d;
	logic [5:0]  ptr_q, ptr_d;
	logic [5:0]  cnt_q, cnt_d;
	logic        busy_q, busy_d;
	logic [15:0] rdata_d;

	function automatic logic is_glob(input logic [8:0] a);
		is_glob = (a[8:2] == 7'h00) && (a[1:0] != 2'b11);
	endfunction

	// Trigger synchronisers, three stages; change counted when stages 2 and 3 agree
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			e1_q <= 1'b0;
			e2_q <= 1'b0;
		end else begin
			s1_q <= {s1_q[1:0], trig_q1_pin};
			s2_q <= {s2_q[1:0], trig_q2_pin};
			if (s1_q[1] == s1_q[2]) e1_q <= s1_q[2];
			if (s2_q[1] == s2_q[2]) e2_q <= s2_q[2];
		end
	end
	wire logic g1 = (s1_q[1] == s1_q[2]) ? s1_q[2] : e1_q;
	wire logic g2 = (s2_q[1] == s2_q[2]) ? s2_q[2] : e2_q;
	wire aqs_mode_t m1 = aqs_mode_t'(q1ctl_q[CTL_MODE_LSB +: 2]);
	wire aqs_mode_t m2 = aqs_mode_t'(q2ctl_q[CTL_MODE_LSB +: 2]);
	// Edge polarity per queue
	wire logic edge1 = q1ctl_q[CTL_EDGE_BIT] ? (g1 & ~e1_q) : (~g1 & e1_q);
	wire logic edge2 = q2ctl_q[CTL_EDGE_BIT] ? (g2 & ~e2_q) : (~g2 & e2_q);
	wire logic sse1 = q1ctl_q[CTL_SSE_BIT];
	wire logic sse2 = q2ctl_q[CTL_SSE_BIT];
	wire logic gate1 = (m1 == AQS_MODE_GATE) && g1;
	// Triggers only count while armed
	wire logic trg1 = sse1 && ((m1 == AQS_MODE_SOFT) || (m1 == AQS_MODE_EDGE && edge1)
		|| gate1);
	wire logic trg2 = sse2 && ((m2 == AQS_MODE_SOFT) || (m2 == AQS_MODE_EDGE && edge2));
	wire logic [9:0] cur_cmd = cmd_mem[ptr_q];
	wire aqs_mode_t cm = qsel_q ? m2 : m1;
	wire logic cur_trg = qsel_q ? trg2 : trg1;

	// Sequencer and control register next state
	always_comb begin
		st_d    = st_q;
		qsel_d  = qsel_q;
		ptr_d   = ptr_q;
		cnt_d   = cnt_q;
		busy_d  = 1'b0;
		q1ctl_d = q1ctl_q;
		q2ctl_d = q2ctl_q;
		cf1_d   = cf1_q;
		pf1_d   = pf1_q;
		cf2_d   = cf2_q;
		pf2_d   = pf2_q;
		tor_d   = tor_q;
		// Software writes and flag clears; hardware sets below win
		if (reg_wr && reg_addr == {1'b0, ADDR_Q1_CONTROL}) q1ctl_d = reg_wdata;
		if (reg_wr && reg_addr == {1'b0, ADDR_Q2_CONTROL}) q2ctl_d = reg_wdata;
		if (reg_wr && reg_addr == {1'b0, ADDR_STATUS_LOW}) begin
			if (reg_wdata[0]) cf1_d = 1'b0;
			if (reg_wdata[1]) pf1_d = 1'b0;
			if (reg_wdata[2]) cf2_d = 1'b0;
			if (reg_wdata[3]) pf2_d = 1'b0;
			if (reg_wdata[4]) tor_d = 1'b0;
		end
		unique case (st_q)
			AQS_IDLE: begin
				// Queue 1 has priority; start at first command
				if (trg1) begin
					st_d   = AQS_RUN;
					qsel_d = 1'b0;
					ptr_d  = 6'h00;
					cnt_d  = 6'h00;
				end else if (trg2) begin
					st_d   = AQS_RUN;
					qsel_d = 1'b1;
					ptr_d  = 6'h00;
					cnt_d  = 6'h00;
				end
			end
			AQS_RUN: begin
				busy_d = 1'b1;
				cnt_d  = cnt_q + 6'h01;
				if (cnt_q == CONV_CYCLES) begin
					cnt_d = 6'h00;
					if (!qsel_q && m1 == AQS_MODE_GATE && !g1) begin
						// Gate closed mid-queue: current command done, stop
						st_d = AQS_IDLE;
						pf1_d = 1'b1;
						q1ctl_d[CTL_SSE_BIT] = 1'b0;
					end else if (cur_cmd[CMD_EOQ_BIT] || ptr_q == 6'h3F) begin
						st_d = AQS_IDLE;
						if (qsel_q) begin
							cf2_d = 1'b1;
							q2ctl_d[CTL_SSE_BIT] = 1'b0;
						end else begin
							cf1_d = 1'b1;
							q1ctl_d[CTL_SSE_BIT] = 1'b0;
						end
					end else begin
						ptr_d = ptr_q + 6'h01;
						if (cur_cmd[CMD_PAUSE_BIT] && cm != AQS_MODE_GATE) begin
							st_d = AQS_PAUSE;
							if (qsel_q) pf2_d = 1'b1;
							else pf1_d = 1'b1;
						end
					end
				end else if (cur_trg && cm == AQS_MODE_EDGE) begin
					tor_d = 1'b1; // Edge while busy; never in soft mode
				end
			end
			AQS_PAUSE: begin
				// Soft mode retriggers next cycle; edge mode waits for edge
				if (cur_trg && cm != AQS_MODE_GATE) st_d = AQS_RUN;
				else if (cm == AQS_MODE_OFF) st_d = AQS_IDLE;
			end
			default: st_d = AQS_IDLE;
		endcase
		// Busy follows the next state, so a status read never lags the run state
		busy_d = (st_d == AQS_RUN);
	end

	// Read mux; global registers need supervisor access
	always_comb begin
		rdata_d = REG_RESET;
		if (reg_rd) begin
			if (reg_addr[8] || reg_addr[7:6] != 2'b00)
				rdata_d = {6'h00, res_mem[reg_addr[5:0]]};
			else if (reg_addr[7:6] == 2'b00 && reg_addr[6] == 1'b0 && reg_addr[5:0] >= 6'h08)
				rdata_d = REG_RESET;
			if (reg_addr[8:6] == 3'b001)
				rdata_d = {6'h00, cmd_mem[reg_addr[5:0]]};
			else if (reg_addr[8:3] == 6'h00) begin
				unique case (reg_addr[2:0])
					3'h0: rdata_d = reg_supervisor ? mcfg_q : REG_RESET;
					3'h1: rdata_d = reg_supervisor ? intr_q : REG_RESET;
					3'h2: rdata_d = reg_supervisor ? test_q : REG_RESET;
					3'h3: rdata_d = hwcfg_q;
					3'h4: rdata_d = q1ctl_q;
					3'h5: rdata_d = q2ctl_q;
					3'h6: rdata_d = {9'h000, busy_q, st_q == AQS_PAUSE, tor_q, pf2_q, cf2_q,
						pf1_q, cf1_q};
					3'h7: rdata_d = {9'h000, qsel_q, ptr_q}; // Last command pointer
				endcase
			end
		end
	end

	// State registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q         <= AQS_IDLE;
			qsel_q       <= 1'b0;
			ptr_q        <= 6'h00;
			cnt_q        <= 6'h00;
			busy_q       <= 1'b0;
			q1ctl_q      <= REG_RESET;
			q2ctl_q      <= REG_RESET;
			mcfg_q       <= REG_RESET;
			intr_q       <= REG_RESET;
			test_q       <= REG_RESET;
			hwcfg_q      <= REG_RESET;
			reg_rdata    <= REG_RESET;
			cf1_q        <= 1'b0;
			pf1_q        <= 1'b0;
			cf2_q        <= 1'b0;
			pf2_q        <= 1'b0;
			tor_q        <= 1'b0;
			conv_start   <= 1'b0;
			conv_channel <= 6'h00;
		end else begin
			st_q    <= st_d;
			qsel_q  <= qsel_d;
			ptr_q   <= ptr_d;
			cnt_q   <= cnt_d;
			busy_q  <= busy_d;
			q1ctl_q <= q1ctl_d;
			q2ctl_q <= q2ctl_d;
			cf1_q   <= cf1_d;
			pf1_q   <= pf1_d;
			cf2_q   <= cf2_d;
			pf2_q   <= pf2_d;
			tor_q   <= tor_d;
			reg_rdata <= rdata_d;
			conv_start <= (st_q == AQS_RUN) && (cnt_q == 6'h00);
			conv_channel <= cur_cmd[5:0];
			// Global writes only in supervisor space
			if (reg_wr && reg_supervisor && is_glob(reg_addr)) begin
				if (reg_addr[1:0] == 2'b00) mcfg_q <= reg_wdata;
				if (reg_addr[1:0] == 2'b01) intr_q <= reg_wdata;
				if (reg_addr[1:0] == 2'b10) test_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == {1'b0, ADDR_HW_CONFIG}) hwcfg_q <= reg_wdata;
		end
	end

	// Table storage, no reset needed
	always_ff @(posedge ref_clk) begin
		if (reg_wr && reg_addr[8:6] == 3'b001) cmd_mem[reg_addr[5:0]] <= reg_wdata[9:0];
		if (st_q == AQS_RUN && cnt_q == CONV_CYCLES) res_mem[ptr_q] <= conv_data;
	end

	// Sequencer properties; all sampled on ref_clk and held off during reset
	a_soft_no_overrun: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cm == AQS_MODE_SOFT) |=> !$rose(tor_q)) else $error("overrun in soft mode");
	a_gate_no_pause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_RUN && !qsel_q && m1 == AQS_MODE_GATE) |=> st_q != AQS_PAUSE)
		else $error("gated pause");
	a_soft_pause_go: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_PAUSE && cm == AQS_MODE_SOFT && (qsel_q ? sse2 : sse1)) |=> st_q == AQS_RUN)
		else $error("soft pause stuck");
	a_disarmed_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_IDLE && !sse1 && !sse2) |=> st_q == AQS_IDLE)
		else $error("start while disarmed");
	a_done_clear_sse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($rose(cf1_q) && !reg_wr) |-> !sse1) else $error("sse1 not cleared");
	a_gate_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_RUN && !qsel_q && m1 == AQS_MODE_GATE && !g1 && cnt_q == CONV_CYCLES)
		|=> (st_q == AQS_IDLE && pf1_q)) else $error("gate close");
	a_gate_close_sse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_RUN && !qsel_q && m1 == AQS_MODE_GATE && !g1 && cnt_q == CONV_CYCLES)
		|=> !sse1) else $error("gate close left enable set");
	a_start_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_IDLE && st_d == AQS_RUN) |=> ptr_q == 6'h00)
		else $error("not first command");
	a_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		conv_start |-> busy_q) else $error("start outside run");
	// Queue-one completion must only appear with the queue back at rest
	a_q1_done_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cf1_q) |-> st_q == AQS_IDLE) else $error("completion while running");
	// An edge-mode pause holds until a qualifying edge; no software kick needed
	a_edge_pause_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_PAUSE && cm == AQS_MODE_EDGE && !cur_trg) |=> st_q == AQS_PAUSE)
		else $error("edge pause left early");
	// Queue two has no gate, so a gate setting there never starts it
	a_q2_no_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == AQS_IDLE && m2 == AQS_MODE_GATE && !trg1) |=> st_q == AQS_IDLE)
		else $error("queue two gated start");
	// Scenario covers
	c_gate_run: cover property (@(posedge ref_clk) gate1 && st_q == AQS_RUN);
	c_edge_pause: cover property (@(posedge ref_clk) st_q == AQS_PAUSE && cm == AQS_MODE_EDGE);
	c_q2_done: cover property (@(posedge ref_clk) $rose(cf2_q));
	c_soft_done: cover property (@(posedge ref_clk) $rose(cf1_q) && m1 == AQS_MODE_SOFT);
	c_gate_cut: cover property (@(posedge ref_clk) $rose(pf1_q) && m1 == AQS_MODE_GATE);
endmodule

// ===== aqs_trig_src.sv
// Model of the external trigger and gate source facing the scan control block.
// Assumes the bench calls its tasks; pins move only just after a rising edge.
module aqs_trig_src (
	input  wire logic ref_clk,
	output logic      trig_q1_pin,
	output logic      trig_q2_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Both pins idle low; queue two is never fired here
	initial begin
		trig_q1_pin = 1'b0;
		trig_q2_pin = 1'b0;
	end

	// Hold each level 8 cycles so the three-flop synchroniser sees it
	task automatic level(input logic v);
		@(posedge ref_clk);
		trig_q1_pin <= v;
		repeat (8) @(posedge ref_clk);
	endtask

	// Open the gate for n cycles, then close it; the far side owns the pin
	task automatic gate_pulse(input int n);
		@(posedge ref_clk);
		trig_q1_pin <= 1'b1;
		repeat (n) @(posedge ref_clk);
		trig_q1_pin <= 1'b0;
	endtask

	// Opposite transition first, so the unwanted polarity is offered too
	task automatic fire(input logic rising);
		level(~rising);
		level(rising);
	endtask
endmodule

// ===== tb.sv
// Self-checking bench for the queue scan control block.
// Assumes the strobe register port and a converter echo built below.
module tb
	import aqs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [8:0]  reg_addr = 9'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        reg_supervisor = 1'b0;
	logic [15:0] reg_rdata;
	logic        trig_q1_pin;
	logic        trig_q2_pin;
	logic [9:0]  conv_data = 10'h000;
	logic        conv_start;
	logic [5:0]  conv_channel;
	logic [5:0]  chq[$];
	logic [15:0] st;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;

	aqs_scan_ctrl #(.CMD_DEPTH(64)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_supervisor(reg_supervisor), .reg_rdata(reg_rdata), .trig_q1_pin(trig_q1_pin),
		.trig_q2_pin(trig_q2_pin), .conv_data(conv_data), .conv_start(conv_start),
		.conv_channel(conv_channel));
	aqs_trig_src u_src (.ref_clk(ref_clk), .trig_q1_pin(trig_q1_pin),
		.trig_q2_pin(trig_q2_pin));

	always #2 ref_clk = ~ref_clk;

	// Converter echo: result carries the channel, so each result is predictable
	always @(posedge ref_clk) begin
		conv_data <= {4'h8, conv_channel};
		if (conv_start === 1'b1) chq.push_back(conv_channel);
	end

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic s);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_supervisor <= s;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, input logic s, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_supervisor <= s;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic rchk(input logic [8:0] a, input logic s, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, s, d);
		chk(d, exp);
	endtask

	// Poll until the queue is no longer running unpaused
	task automatic wait_stop;
		logic [15:0] s;
		repeat (12) @(posedge ref_clk);
		for (int i = 0; i < 40; i++) begin
			rd({1'b0, ADDR_STATUS_LOW}, 1'b1, s);
			if (s[6:5] !== 2'b10) break;
		end
	endtask

	task automatic chk_chans(input int n, input logic [5:0] first);
		chk(16'(chq.size()), 16'(n));
		for (int i = 0; i < chq.size() && i < n; i++) chk({10'h000, chq[i]}, 16'(first + i));
		chq.delete();
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk({1'b0, ADDR_Q1_CONTROL}, 1'b1, REG_RESET);
		wr({1'b0, ADDR_MODULE_CONFIG}, 16'h00FF, 1'b0);
		rchk({1'b0, ADDR_MODULE_CONFIG}, 1'b1, REG_RESET);
		wr({1'b0, ADDR_MODULE_CONFIG}, 16'h00A5, 1'b1);
		rchk({1'b0, ADDR_MODULE_CONFIG}, 1'b1, 16'h00A5);
		rchk({1'b0, ADDR_MODULE_CONFIG}, 1'b0, REG_RESET);
		wr(9'h07F, 16'hFFFF, 1'b1);
		rchk(9'h07F, 1'b1, 16'h03FF);
		rchk(9'h008, 1'b1, 16'h0000);
		// Queue: channel 5, channel 6 with pause, channel 7 ending the queue
		wr(9'h040, 16'h0005, 1'b1);
		wr(9'h041, 16'h0206, 1'b1);
		wr(9'h042, 16'h0107, 1'b1);
		wr({1'b0, ADDR_Q1_CONTROL}, 16'h0003, 1'b1);
		wait_stop();
		chk_chans(3, 6'h05);
		rd({1'b0, ADDR_STATUS_LOW}, 1'b1, st);
		chk(st & 16'h0011, 16'h0001);
		rchk(9'h080, 1'b1, 16'h0205);
		rchk(9'h0C0, 1'b1, 16'h0205);
		rchk(9'h100, 1'b1, 16'h0205);
		repeat (30) @(posedge ref_clk);
		chk_chans(0, 6'h05);
		// Queue two in software mode walks the same table
		wr({1'b0, ADDR_Q2_CONTROL}, 16'h0003, 1'b1);
		wait_stop();
		chk_chans(3, 6'h05);
		rd({1'b0, ADDR_STATUS_LOW}, 1'b1, st);
		chk(st & 16'h0014, 16'h0004);
		rchk({1'b0, ADDR_Q2_CONTROL}, 1'b1, 16'h0002);
		// Edge mode, rising then falling polarity
		for (int p = 0; p < 2; p++) begin
			wr({1'b0, ADDR_STATUS_LOW}, 16'h001F, 1'b1);
			u_src.level(p[0]);
			wr({1'b0, ADDR_Q1_CONTROL}, {12'h000, ~p[0], 3'b100}, 1'b1);
			u_src.fire(~p[0]);
			repeat (20) @(posedge ref_clk);
			chk_chans(0, 6'h05);
			wr({1'b0, ADDR_Q1_CONTROL}, {12'h000, ~p[0], 3'b101}, 1'b1);
			u_src.fire(~p[0]);
			wait_stop();
			chk_chans(2, 6'h05);
			u_src.fire(~p[0]);
			wait_stop();
			chk_chans(1, 6'h07);
			rchk({1'b0, ADDR_Q1_CONTROL}, 1'b1, {12'h000, ~p[0], 3'b100});
		end
		// Gated mode: open gate long enough for a whole run
		u_src.level(1'b0);
		wr({1'b0, ADDR_STATUS_LOW}, 16'h001F, 1'b1);
		wr({1'b0, ADDR_Q1_CONTROL}, 16'h0007, 1'b1);
		u_src.level(1'b1);
		wait_stop();
		chk_chans(3, 6'h05);
		rd({1'b0, ADDR_STATUS_LOW}, 1'b1, st);
		chk(st & 16'h0003, 16'h0001);
		rchk({1'b0, ADDR_Q1_CONTROL}, 1'b1, 16'h0006);
		// Gate closes during the first command
		u_src.level(1'b0);
		wr({1'b0, ADDR_STATUS_LOW}, 16'h001F, 1'b1);
		wr({1'b0, ADDR_Q1_CONTROL}, 16'h0007, 1'b1);
		u_src.gate_pulse(4);
		repeat (40) @(posedge ref_clk);
		chk(16'(chq.size()), 16'h0001);
		chq.delete();
		rd({1'b0, ADDR_STATUS_LOW}, 1'b1, st);
		chk(st & 16'h0003, 16'h0002);
		rchk({1'b0, ADDR_Q1_CONTROL}, 1'b1, 16'h0006);
		wrap_up();
	end

endmodule
